// ### core/tct_pkg.sv
/*
 * Package for the timer and capture time base: register map, field positions,
 * reset values, capture modes and status layout.
 * Assumes a byte-wide register port with read data one cycle after the strobe.
 */
package tct_pkg;
   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_CONFIG = 8'h16;
   localparam logic [7:0] OFF_PERIOD1 = 8'h20;
   localparam logic [7:0] OFF_PERIOD2 = 8'h21;
   localparam logic [7:0] OFF_TMR1 = 8'h22;
   localparam logic [7:0] OFF_TMR2 = 8'h23;
   localparam logic [7:0] OFF_WIDE_L = 8'h24;
   localparam logic [7:0] OFF_WIDE_H = 8'h25;
   localparam logic [7:0] OFF_CAP1_L = 8'h26;
   localparam logic [7:0] OFF_CAP1_H = 8'h27;
   localparam logic [7:0] OFF_CAP2_L = 8'h28;
   localparam logic [7:0] OFF_CAP2_H = 8'h29;
   localparam logic [7:0] OFF_CAP3_L = 8'h2A;
   localparam logic [7:0] OFF_CAP3_H = 8'h2B;
   localparam logic [7:0] OFF_CAP4_L = 8'h2C;
   localparam logic [7:0] OFF_CAP4_H = 8'h2D;
   localparam logic [7:0] OFF_CTRL2 = 8'h2E;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h2F;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h30;
   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int CFG_T1CS = 0;
   localparam int CFG_T2CS = 1;
   localparam int CFG_T3CS = 2;
   localparam int CFG_JOIN = 3;
   localparam int CFG_CAP1_LO = 4;
   localparam int CFG_CAP2_LO = 6;
   localparam int CTRL2_CAP1_SEL = 0;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [7:0] CTRL2_RESET = 8'h00;
   localparam logic [7:0] PERIOD_RESET = 8'hFF;
   localparam logic [3:0] PRESCALE_DIV = 4'h4;
   localparam logic [3:0] DIV_LAST = 4'h3;
   // interrupt status bits
   localparam int IRQ_T1 = 0;
   localparam int IRQ_T2 = 1;
   localparam int IRQ_T3 = 2;
   localparam int IRQ_CAP0 = 3;
   localparam int IRQ_OVR1 = 7;
   // ---------------------------------------------------------------
   // capture modes
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      TCT_CAP_FALL = 2'b00,
      TCT_CAP_RISE = 2'b01,
      TCT_CAP_RISE4 = 2'b10,
      TCT_CAP_RISE16 = 2'b11
   } tct_cap_mode_t;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } tct_bus_req_t;
endpackage : tct_pkg

// ### core/tct_timebase.sv
/*
 * Timer and capture time base: two 8-bit period timers that may join into one
 * 16-bit timer, a 16-bit wide timer with period or capture pair, four capture
 * channels, byte register port, sticky interrupt status with mask.
 * Assumes all pin inputs are already synchronous to clk_sys_i.
 */
// What this block does
// - two 8-bit up timers, each with period register and overflow flag
// - 8-bit timers count instruction clock or falling edges of shared pin
// - config bit 3 joins the two 8-bit timers into one 16-bit timer
// - 16-bit wide timer; extra pair is its period or capture one
// - config bit 2 picks instruction clock or wide timer pin
// - all four captures latch the wide timer; channels 2-4 own pairs
// - pwm one uses first timer; pwm two and three use either timer
// - capture mode 00 falling, 01 rising, 11 every 16th rising edge
// - capture two mode in bits 7-6, capture one in 5-4, offset 16h
// - 8-bit timers give the pwm time base, periods set pwm period
// - capture before both bytes read sets overrun, keeps oldest value
`timescale 1ns/1ns
module tct_timebase (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic shared_ext_clock_pin_i,
   input wire logic wide_timer_ext_clock_pin_i,
   input wire logic [3:0] capture_pin_i,
   output logic [7:0] rdata_o,
   output logic irq_o,
   output logic [2:0] pwm_tick_o
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] config_reg;
      logic [7:0] ctrl2;
      logic [7:0] period1;
      logic [7:0] period2;
      logic [7:0] tmr1;
      logic [7:0] tmr2;
      logic [15:0] wide;
      logic [3:0][15:0] cap;
      logic [3:0] cap_full;
      logic [3:0] rd_lo;
      logic [3:0] rd_hi;
      logic [3:0][3:0] edge_cnt;
      logic [3:0] cap_prev;
      logic shared_prev;
      logic wide_prev;
      logic [3:0] div;
      logic [7:0] stat;
      logic [7:0] mask;
      logic [7:0] rdata;
      logic irq;
      logic [2:0] pwm_tick;
   } tct_state_t;

   tct_state_t st;
   tct_state_t next_st;
   tct_pkg::tct_bus_req_t bus;

   assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

   // capture mode of a channel; channels 3 and 4 share the first field
   function automatic tct_pkg::tct_cap_mode_t cap_mode(input logic [7:0] cfg, input int ch);
      if (ch == 1) begin
         cap_mode = tct_pkg::tct_cap_mode_t'(cfg[tct_pkg::CFG_CAP2_LO +: 2]);
      end else begin
         cap_mode = tct_pkg::tct_cap_mode_t'(cfg[tct_pkg::CFG_CAP1_LO +: 2]);
      end
   endfunction : cap_mode

   logic tick_int;
   logic shared_fall;
   logic wide_ext_rise;
   logic inc1;
   logic inc2;
   logic inc3;
   logic ovf1;
   logic ovf2;
   logic ovf3;
   logic cap1_mode;
   logic [3:0] cap_event;
   logic [3:0] hit;
   logic [7:0] events;

   always_comb begin
      tick_int = (st.div == tct_pkg::DIV_LAST);
      shared_fall = st.shared_prev & ~shared_ext_clock_pin_i;
      wide_ext_rise = ~st.wide_prev & wide_timer_ext_clock_pin_i;
      inc1 = st.config_reg[tct_pkg::CFG_T1CS] ? shared_fall : tick_int;
      inc2 = st.config_reg[tct_pkg::CFG_T2CS] ? shared_fall : tick_int;
      inc3 = st.config_reg[tct_pkg::CFG_T3CS] ? wide_ext_rise : tick_int;
      cap1_mode = st.ctrl2[tct_pkg::CTRL2_CAP1_SEL];
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      next_st = st;
      events = 8'h00;
      ovf1 = 1'b0;
      ovf2 = 1'b0;
      ovf3 = 1'b0;
      cap_event = 4'h0;
      hit = 4'h0;
      next_st.shared_prev = shared_ext_clock_pin_i;
      next_st.wide_prev = wide_timer_ext_clock_pin_i;
      next_st.cap_prev = capture_pin_i;
      next_st.div = tick_int ? 4'h0 : st.div + 4'h1;
      next_st.rdata = 8'h00;
      // 8-bit timers, or one 16-bit timer on the first timer's clock
      if (st.config_reg[tct_pkg::CFG_JOIN]) begin
         if (inc1) begin
            if ({st.tmr2, st.tmr1} == {st.period2, st.period1}) begin
               next_st.tmr1 = 8'h00;
               next_st.tmr2 = 8'h00;
               ovf1 = 1'b1;
            end else begin
               {next_st.tmr2, next_st.tmr1} = {st.tmr2, st.tmr1} + 16'h0001;
            end
         end
      end else begin
         if (inc1) begin
            ovf1 = (st.tmr1 == st.period1);
            next_st.tmr1 = ovf1 ? 8'h00 : st.tmr1 + 8'h01;
         end
         if (inc2) begin
            ovf2 = (st.tmr2 == st.period2);
            next_st.tmr2 = ovf2 ? 8'h00 : st.tmr2 + 8'h01;
         end
      end
      // pwm one on the first timer, pwm two and three on a selectable one
      next_st.pwm_tick[0] = ovf1;
      next_st.pwm_tick[1] = st.ctrl2[1] ? (ovf2 | (ovf1 & st.config_reg[3])) : ovf1;
      next_st.pwm_tick[2] = st.ctrl2[2] ? (ovf2 | (ovf1 & st.config_reg[3])) : ovf1;
      // wide timer: wraps at period when pair is a period register
      if (inc3) begin
         if (!cap1_mode && st.wide == st.cap[0]) begin
            next_st.wide = 16'h0000;
            ovf3 = 1'b1;
         end else begin
            next_st.wide = st.wide + 16'h0001;
            ovf3 = (st.wide == 16'hFFFF);
         end
      end
      // capture edge qualification
      for (int c = 0; c < 4; c++) begin
         logic rise;
         logic fall;
         rise = ~st.cap_prev[c] & capture_pin_i[c];
         fall = st.cap_prev[c] & ~capture_pin_i[c];
         unique case (cap_mode(st.config_reg, c))
            tct_pkg::TCT_CAP_FALL: cap_event[c] = fall;
            tct_pkg::TCT_CAP_RISE: cap_event[c] = rise;
            tct_pkg::TCT_CAP_RISE4: begin
               if (rise) next_st.edge_cnt[c] = st.edge_cnt[c] + 4'h1;
               cap_event[c] = rise && st.edge_cnt[c][1:0] == 2'h3;
            end
            tct_pkg::TCT_CAP_RISE16: begin
               if (rise) next_st.edge_cnt[c] = st.edge_cnt[c] + 4'h1;
               cap_event[c] = rise && st.edge_cnt[c] == 4'hF;
            end
         endcase
         if (c == 0 && !cap1_mode) cap_event[c] = 1'b0;
         if (cap_event[c]) begin
            if (st.cap_full[c]) begin
               hit[c] = 1'b1;
            end else begin
               next_st.cap[c] = st.wide;
               next_st.cap_full[c] = 1'b1;
               next_st.rd_lo[c] = 1'b0;
               next_st.rd_hi[c] = 1'b0;
            end
         end
      end
      // ---------------------------------------------------------------
      // register port
      // ---------------------------------------------------------------
      if (bus.wr) begin
         unique case (bus.addr)
            tct_pkg::OFF_CONFIG: begin
               next_st.config_reg = bus.wdata;
               // restart edge prescalers so a new mode counts from zero
               next_st.edge_cnt = '0;
            end
            tct_pkg::OFF_CTRL2: next_st.ctrl2 = bus.wdata;
            tct_pkg::OFF_PERIOD1: next_st.period1 = bus.wdata;
            tct_pkg::OFF_PERIOD2: next_st.period2 = bus.wdata;
            tct_pkg::OFF_TMR1: next_st.tmr1 = bus.wdata;
            tct_pkg::OFF_TMR2: next_st.tmr2 = bus.wdata;
            tct_pkg::OFF_WIDE_L: next_st.wide[7:0] = bus.wdata;
            tct_pkg::OFF_WIDE_H: next_st.wide[15:8] = bus.wdata;
            tct_pkg::OFF_CAP1_L: if (!cap1_mode) next_st.cap[0][7:0] = bus.wdata;
            tct_pkg::OFF_CAP1_H: if (!cap1_mode) next_st.cap[0][15:8] = bus.wdata;
            tct_pkg::OFF_IRQ_MASK: next_st.mask = bus.wdata;
            default: ;
         endcase
      end
      if (bus.rd) begin
         for (int c = 0; c < 4; c++) begin
            if (bus.addr == tct_pkg::OFF_CAP1_L + 8'(2 * c)) begin
               next_st.rdata = st.cap[c][7:0];
               next_st.rd_lo[c] = 1'b1;
            end
            if (bus.addr == tct_pkg::OFF_CAP1_H + 8'(2 * c)) begin
               next_st.rdata = st.cap[c][15:8];
               next_st.rd_hi[c] = 1'b1;
            end
         end
         unique case (bus.addr)
            tct_pkg::OFF_CONFIG: next_st.rdata = st.config_reg;
            tct_pkg::OFF_CTRL2: next_st.rdata = st.ctrl2;
            tct_pkg::OFF_PERIOD1: next_st.rdata = st.period1;
            tct_pkg::OFF_PERIOD2: next_st.rdata = st.period2;
            tct_pkg::OFF_TMR1: next_st.rdata = st.tmr1;
            tct_pkg::OFF_TMR2: next_st.rdata = st.tmr2;
            tct_pkg::OFF_WIDE_L: next_st.rdata = st.wide[7:0];
            tct_pkg::OFF_WIDE_H: next_st.rdata = st.wide[15:8];
            tct_pkg::OFF_IRQ_STAT: next_st.rdata = st.stat;
            tct_pkg::OFF_IRQ_MASK: next_st.rdata = st.mask;
            default: ;
         endcase
      end
      // both bytes read frees the channel
      for (int c = 0; c < 4; c++) begin
         if (next_st.rd_lo[c] && next_st.rd_hi[c] && !(cap_event[c] && !st.cap_full[c])) begin
            next_st.cap_full[c] = 1'b0;
         end
      end
      // sticky status, set wins over write-one-to-clear
      events[tct_pkg::IRQ_T1] = ovf1;
      events[tct_pkg::IRQ_T2] = ovf2;
      events[tct_pkg::IRQ_T3] = ovf3;
      events[tct_pkg::IRQ_CAP0 +: 4] = cap_event & ~st.cap_full;
      events[tct_pkg::IRQ_OVR1] = |hit;
      if (bus.wr && bus.addr == tct_pkg::OFF_IRQ_STAT) begin
         next_st.stat = st.stat & ~bus.wdata;
      end
      next_st.stat = next_st.stat | events;
      next_st.irq = |(next_st.stat & next_st.mask);
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= '0;
         st.config_reg <= tct_pkg::CONFIG_RESET;
         st.ctrl2 <= tct_pkg::CTRL2_RESET;
         st.period1 <= tct_pkg::PERIOD_RESET;
         st.period2 <= tct_pkg::PERIOD_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign rdata_o = st.rdata;
   assign irq_o = st.irq;
   assign pwm_tick_o = st.pwm_tick;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_cfg_reset;
      @(posedge clk_sys_i) $rose(rst_n_i) |-> st.config_reg == 8'h00;
   endproperty
   a_cfg_reset: assert property (p_cfg_reset) else $error("config not zero after reset");

   property p_t1_wrap;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
         (inc1 && !st.config_reg[3] && st.tmr1 == st.period1 && !bus.wr) |=> st.tmr1 == 8'h00;
   endproperty
   a_t1_wrap: assert property (p_t1_wrap) else $error("timer one missed period wrap");

   property p_t1_int;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
         (!st.config_reg[0] && !st.config_reg[3] && tick_int && st.tmr1 != st.period1 && !bus.wr)
         |=> st.tmr1 == $past(st.tmr1) + 8'h01;
   endproperty
   a_t1_int: assert property (p_t1_int) else $error("timer one missed internal tick");

   property p_join;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
         (st.config_reg[3] && inc1 && st.tmr1 == 8'hFF
          && st.tmr2 != st.period2 && !bus.wr)
         |=> st.tmr1 == 8'h00 && st.tmr2 == $past(st.tmr2) + 8'h01;
   endproperty
   a_join: assert property (p_join) else $error("joined carry lost");

   property p_cap_keep;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
         (st.cap_full[1] && cap_event[1]) |=> st.cap[1] == $past(st.cap[1]) && st.stat[7];
   endproperty
   a_cap_keep: assert property (p_cap_keep) else $error("overrun lost oldest value");

   property p_cap_take;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
         (!st.cap_full[2] && cap_event[2]) |=> st.cap[2] == $past(st.wide);
   endproperty
   a_cap_take: assert property (p_cap_take) else $error("capture missed wide timer");

   property p_cap_fall;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
         (st.config_reg[7:6] == 2'b00 && st.cap_prev[1] && !capture_pin_i[1]) |-> cap_event[1];
   endproperty
   a_cap_fall: assert property (p_cap_fall) else $error("falling capture missed");

   property p_wide_ext;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
         (st.config_reg[2] && !wide_ext_rise && !bus.wr) |=> st.wide == $past(st.wide);
   endproperty
   a_wide_ext: assert property (p_wide_ext) else $error("wide timer moved without pin edge");

   property p_irq;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
         (st.stat[tct_pkg::IRQ_T1] && st.mask[tct_pkg::IRQ_T1] && !bus.wr) |=> irq_o;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule : tct_timebase

// ### tb/tct_pin_model.sv
/*
 * Pin-side model: shared external clock, wide timer clock and four capture
 * inputs. Assumes the bench calls pulse() and clk_sys_i runs free.
 */
`timescale 1ns/1ns
module tct_pin_model (
   input wire logic clk_sys_i,
   output logic shared_ext_clock_pin_o,
   output logic wide_timer_ext_clock_pin_o,
   output logic [3:0] capture_pin_o
);
   // shared pin idles high so the first flip is a falling edge
   initial begin
      shared_ext_clock_pin_o = 1'b1;
      wide_timer_ext_clock_pin_o = 1'b0;
      capture_pin_o = 4'h0;
   end
   task automatic flip(input int sel);
      case (sel)
         0: shared_ext_clock_pin_o <= ~shared_ext_clock_pin_o;
         1: wide_timer_ext_clock_pin_o <= ~wide_timer_ext_clock_pin_o;
         default: capture_pin_o[sel-2] <= ~capture_pin_o[sel-2];
      endcase
   endtask : flip
   // sel 0 shared, 1 wide, 2..5 capture; each level held two cycles
   task automatic pulse(input int sel, input int n);
      for (int i = 0; i < n; i++) begin
         repeat (2) @(posedge clk_sys_i);
         flip(sel);
         repeat (2) @(posedge clk_sys_i);
         flip(sel);
      end
   endtask : pulse
endmodule : tct_pin_model

// ### tb/tct_timebase_tb.sv
/*
 * Self-checking bench for the timer and capture time base.
 * Assumes the pin model of tct_pin_model and a free-running 50 MHz clock.
 */
`timescale 1ns/1ns
module tct_timebase_tb;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic sh_pin, wide_pin, pend = 1'b0;
   logic [3:0] cap_pin;
   logic [7:0] rdata_o, r;
   logic irq_o;
   logic [2:0] pwm_tick_o;
   logic [7:0] exp_q[$], msk_q[$];
   int err_total = 0, n_tests = 0, cyc = 0;
   int cnt[3];
   int nrise[4] = '{1, 1, 4, 16};
   initial forever #10 clk_sys_i = ~clk_sys_i;
   tct_timebase u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .shared_ext_clock_pin_i(sh_pin),
      .wide_timer_ext_clock_pin_i(wide_pin), .capture_pin_i(cap_pin),
      .rdata_o(rdata_o), .irq_o(irq_o), .pwm_tick_o(pwm_tick_o));
   tct_pin_model u_pins (.clk_sys_i(clk_sys_i), .shared_ext_clock_pin_o(sh_pin),
      .wide_timer_ext_clock_pin_o(wide_pin), .capture_pin_o(cap_pin));
   // ---------------------------------------------------------------
   // bus tasks and comparison
   // ---------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge clk_sys_i);
      rd_i <= 1'b1;
      addr_i <= a;
      exp_q.push_back(e);
      msk_q.push_back(m);
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
   endtask : rd
   // read data stand in the cycle after the read edge only
   always @(posedge clk_sys_i) begin
      if (pend) check(rdata_o & msk_q[0], exp_q[0] & msk_q[0]);
      if (pend) void'(exp_q.pop_front());
      if (pend) void'(msk_q.pop_front());
      pend = rd_i;
   end
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         tally_and_finish();
      end
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(75));
      repeat (3) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      rd(tct_pkg::OFF_CONFIG, 8'h00, 8'hFF);
      rd(tct_pkg::OFF_PERIOD1, 8'hFF, 8'hFF);
      rd(8'hFF, 8'h00, 8'hFF);
      r = $urandom;
      wr(tct_pkg::OFF_CONFIG, r);
      rd(tct_pkg::OFF_CONFIG, r, 8'hFF);
      // external counting, separate then joined
      wr(tct_pkg::OFF_CONFIG, 8'h01);
      wr(tct_pkg::OFF_TMR1, 8'h00);
      u_pins.pulse(0, 3);
      rd(tct_pkg::OFF_TMR1, 8'h03, 8'hFF);
      wr(tct_pkg::OFF_CONFIG, 8'h02);
      wr(tct_pkg::OFF_TMR2, 8'h00);
      u_pins.pulse(0, 2);
      rd(tct_pkg::OFF_TMR2, 8'h02, 8'hFF);
      wr(tct_pkg::OFF_CONFIG, 8'h09);
      wr(tct_pkg::OFF_TMR1, 8'hFE);
      wr(tct_pkg::OFF_TMR2, 8'h00);
      u_pins.pulse(0, 3);
      rd(tct_pkg::OFF_TMR1, 8'h01, 8'hFF);
      rd(tct_pkg::OFF_TMR2, 8'h01, 8'hFF);
      // overflow interrupt, mask and clear
      wr(tct_pkg::OFF_CONFIG, 8'h00);
      wr(tct_pkg::OFF_PERIOD1, 8'h03);
      wr(tct_pkg::OFF_TMR1, 8'h00);
      wr(tct_pkg::OFF_IRQ_STAT, 8'hFF);
      wr(tct_pkg::OFF_IRQ_MASK, 8'h01);
      for (int i = 0; i < 40 && irq_o !== 1'b1; i++) @(posedge clk_sys_i);
      check(irq_o, 1'b1);
      wr(tct_pkg::OFF_IRQ_MASK, 8'h00);
      repeat (2) @(posedge clk_sys_i);
      check(irq_o, 1'b0);
      wr(tct_pkg::OFF_CONFIG, 8'h01);
      wr(tct_pkg::OFF_IRQ_STAT, 8'h01);
      rd(tct_pkg::OFF_IRQ_STAT, 8'h00, 8'h01);
      wr(tct_pkg::OFF_IRQ_MASK, 8'h01);
      repeat (2) @(posedge clk_sys_i);
      check(irq_o, 1'b0);
      // pwm time base: pwm3 on second timer, pwm1 and pwm2 on first
      wr(tct_pkg::OFF_CONFIG, 8'h00);
      wr(tct_pkg::OFF_PERIOD2, 8'h07);
      wr(tct_pkg::OFF_TMR1, 8'h00);
      wr(tct_pkg::OFF_TMR2, 8'h00);
      wr(tct_pkg::OFF_CTRL2, 8'h04);
      repeat (40) @(posedge clk_sys_i);
      cnt = '{0, 0, 0};
      repeat (64) begin
         @(posedge clk_sys_i);
         for (int b = 0; b < 3; b++) cnt[b] += (pwm_tick_o[b] === 1'b1);
      end
      check(8'(cnt[0]), 8'h04);
      check(8'(cnt[1]), 8'h04);
      check(8'(cnt[2]), 8'h02);
      // capture modes on channel two, wide timer frozen on its pin
      wr(tct_pkg::OFF_CTRL2, 8'h01);
      wr(tct_pkg::OFF_CONFIG, 8'h04);
      wr(tct_pkg::OFF_WIDE_L, 8'h00);
      wr(tct_pkg::OFF_WIDE_H, 8'h00);
      for (int m = 0; m < 4; m++) begin
         wr(tct_pkg::OFF_CONFIG, {2'(m), 6'h04});
         wr(tct_pkg::OFF_IRQ_STAT, 8'hFF);
         if (nrise[m] > 1) u_pins.pulse(3, nrise[m] - 1);
         if (nrise[m] > 1) rd(tct_pkg::OFF_IRQ_STAT, 8'h00, 8'h10);
         u_pins.pulse(3, 1);
         rd(tct_pkg::OFF_IRQ_STAT, 8'h10, 8'h10);
         rd(tct_pkg::OFF_CAP2_L, 8'h00, 8'hFF);
         rd(tct_pkg::OFF_CAP2_H, 8'h00, 8'hFF);
      end
      // captured value, overrun keeps the oldest
      wr(tct_pkg::OFF_CONFIG, 8'h54);
      wr(tct_pkg::OFF_IRQ_STAT, 8'hFF);
      u_pins.pulse(1, 5);
      u_pins.pulse(3, 1);
      u_pins.pulse(2, 1);
      u_pins.pulse(4, 1);
      u_pins.pulse(5, 1);
      u_pins.pulse(1, 2);
      u_pins.pulse(3, 1);
      rd(tct_pkg::OFF_IRQ_STAT, 8'hF8, 8'hF8);
      rd(tct_pkg::OFF_CAP2_L, 8'h05, 8'hFF);
      rd(tct_pkg::OFF_CAP2_H, 8'h00, 8'hFF);
      rd(tct_pkg::OFF_CAP1_L, 8'h05, 8'hFF);
      rd(tct_pkg::OFF_CAP1_H, 8'h00, 8'hFF);
      rd(tct_pkg::OFF_CAP3_L, 8'h05, 8'hFF);
      rd(tct_pkg::OFF_CAP3_H, 8'h00, 8'hFF);
      rd(tct_pkg::OFF_CAP4_L, 8'h05, 8'hFF);
      rd(tct_pkg::OFF_CAP4_H, 8'h00, 8'hFF);
      // pair as period: wide timer wraps to zero on the third pin edge
      wr(tct_pkg::OFF_CTRL2, 8'h00);
      wr(tct_pkg::OFF_CAP1_L, 8'h02);
      wr(tct_pkg::OFF_CAP1_H, 8'h00);
      wr(tct_pkg::OFF_WIDE_L, 8'h00);
      wr(tct_pkg::OFF_WIDE_H, 8'h00);
      wr(tct_pkg::OFF_IRQ_STAT, 8'hFF);
      u_pins.pulse(1, 3);
      rd(tct_pkg::OFF_WIDE_L, 8'h00, 8'hFF);
      rd(tct_pkg::OFF_IRQ_STAT, 8'h04, 8'h04);
      repeat (3) @(posedge clk_sys_i);
      tally_and_finish();
   end
endmodule : tct_timebase_tb
